// file: common/wit_pkg.sv
// constants, field layouts and types for the watch interval timer
// assumes one core clock; register byte address is four times the index
package wit_pkg;

   // structure
   localparam int PRE_W = 11;
   localparam int CNT_W = 5;
   localparam int DIV_LOG2 = 7;
   localparam int MIN_TAP = 4;
   localparam int COUNT_TAP = 9;
   localparam int ADDR_MIN_W = 18;

   // register indices, byte address = index * 4
   localparam logic [15:0] IDX_MODE = 16'hFF8F;
   localparam logic [15:0] IDX_STATUS = 16'hFF90;
   localparam logic [15:0] IDX_CLEAR = 16'hFF91;
   localparam logic [15:0] IDX_ENABLE = 16'hFF92;
   localparam logic [15:0] IDX_BIT_SET = 16'hFF93;
   localparam logic [15:0] IDX_BIT_CLR = 16'hFF94;
   localparam logic [15:0] IDX_STATE = 16'hFF95;

   // reset values
   localparam logic [7:0] MODE_RST = 8'h00;
   localparam logic [1:0] EVT_RST = 2'h0;

   // watch period codes
   localparam logic [1:0] PER_2_14 = 2'h0;
   localparam logic [1:0] PER_2_13 = 2'h1;
   localparam logic [1:0] PER_2_5 = 2'h2;
   localparam logic [1:0] PER_2_4 = 2'h3;

   // axi responses
   localparam logic [1:0] AXI_OKAY = 2'h0;
   localparam logic [1:0] AXI_DECERR = 2'h3;

   typedef struct packed {
      logic clock_source_select;
      logic [2:0] prescale_interval;
      logic [1:0] watch_period;
      logic counter_run;
      logic timer_enable;
   } wit_mode_s;

   typedef struct packed {
      logic interval;
      logic watch;
   } wit_evt_s;

   // state readback layout
   typedef struct packed {
      logic [10:0] rsvd_hi;
      logic [4:0] counter;
      logic [4:0] rsvd_lo;
      logic [10:0] prescaler;
   } wit_state_s;

   typedef enum logic [2:0] {
      REG_MODE,
      REG_STATUS,
      REG_CLEAR,
      REG_ENABLE,
      REG_BIT_SET,
      REG_BIT_CLR,
      REG_STATE,
      REG_NONE
   } wit_reg_e;

endpackage

// file: verilog/wit_prescaler.sv
// prescaler of the watch interval timer with one pulse per power-of-two tap
// assumes tick_i is a single-cycle watch clock pulse on core_clk_i
`timescale 1ns/1ps
`default_nettype none
module wit_prescaler #(
   parameter int PRE_W = 11
) (
   // clock and reset
   input wire logic core_clk_i,
   input wire logic resetn_i,
   // control
   input wire logic tick_i,
   input wire logic clear_i,
   // state
   output logic [PRE_W-1:0] count_o,
   output logic [PRE_W:1] tap_o
);

   generate
      if (PRE_W < 2) begin : g_chk
         $error("wit_prescaler needs PRE_W of at least 2");
      end
   endgenerate

   logic [PRE_W-1:0] count_ff;
   logic [PRE_W:1] tap_ff;

   // free count of watch clock periods
   always_ff @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         count_ff <= '0;
      end else if (clear_i) begin
         count_ff <= '0;
      end else if (tick_i) begin
         count_ff <= count_ff + {{(PRE_W-1){1'b0}}, 1'b1};
      end
   end

   // tap k pulses once every 2^k ticks
   generate
      for (genvar k = 1; k <= PRE_W; k++) begin : g_tap
         always_ff @(posedge core_clk_i or negedge resetn_i) begin
            if (!resetn_i) begin
               tap_ff[k] <= 1'b0;
            end else begin
               tap_ff[k] <= !clear_i && tick_i && (&count_ff[k-1:0]);
            end
         end
      end
   endgenerate

   assign count_o = count_ff;
   assign tap_o = tap_ff;

endmodule // wit_prescaler
`default_nettype wire

// file: verilog/wit_top.sv
// watch interval timer: mode register, prescaler, 5-bit counter, interrupts
// assumes an axi4-lite master on core_clk_i and a free subsystem clock pin
`timescale 1ns/1ps
`default_nettype none
module wit_top #(
   parameter int AXI_ADDR_W = 20
) (
   // clock and reset
   input wire logic core_clk_i,
   input wire logic resetn_i,
   // subsystem clock pin
   input wire logic sub_clk_i,
   // axi4-lite write address
   input wire logic s_axi_awvalid_i,
   output logic s_axi_awready_o,
   input wire logic [AXI_ADDR_W-1:0] s_axi_awaddr_i,
   // axi4-lite write data
   input wire logic s_axi_wvalid_i,
   output logic s_axi_wready_o,
   input wire logic [31:0] s_axi_wdata_i,
   input wire logic [3:0] s_axi_wstrb_i,
   // axi4-lite write response
   output logic s_axi_bvalid_o,
   input wire logic s_axi_bready_i,
   output logic [1:0] s_axi_bresp_o,
   // axi4-lite read address
   input wire logic s_axi_arvalid_i,
   output logic s_axi_arready_o,
   input wire logic [AXI_ADDR_W-1:0] s_axi_araddr_i,
   // axi4-lite read data
   output logic s_axi_rvalid_o,
   input wire logic s_axi_rready_i,
   output logic [31:0] s_axi_rdata_o,
   output logic [1:0] s_axi_rresp_o,
   // events and interrupt
   output logic watch_irq_o,
   output logic interval_irq_o,
   output logic irq_o
);

   generate
      if (AXI_ADDR_W < wit_pkg::ADDR_MIN_W || AXI_ADDR_W > 32) begin : g_chk
         $error("wit_top needs AXI_ADDR_W between 18 and 32");
      end
   endgenerate

   // address decode shared by read and write
   function automatic wit_pkg::wit_reg_e decode(input logic [AXI_ADDR_W-1:0] addr);
      logic [AXI_ADDR_W-3:0] idx;
      idx = addr[AXI_ADDR_W-1:2];
      if (idx == (AXI_ADDR_W-2)'(wit_pkg::IDX_MODE)) begin
         return wit_pkg::REG_MODE;
      end else if (idx == (AXI_ADDR_W-2)'(wit_pkg::IDX_STATUS)) begin
         return wit_pkg::REG_STATUS;
      end else if (idx == (AXI_ADDR_W-2)'(wit_pkg::IDX_CLEAR)) begin
         return wit_pkg::REG_CLEAR;
      end else if (idx == (AXI_ADDR_W-2)'(wit_pkg::IDX_ENABLE)) begin
         return wit_pkg::REG_ENABLE;
      end else if (idx == (AXI_ADDR_W-2)'(wit_pkg::IDX_BIT_SET)) begin
         return wit_pkg::REG_BIT_SET;
      end else if (idx == (AXI_ADDR_W-2)'(wit_pkg::IDX_BIT_CLR)) begin
         return wit_pkg::REG_BIT_CLR;
      end else if (idx == (AXI_ADDR_W-2)'(wit_pkg::IDX_STATE)) begin
         return wit_pkg::REG_STATE;
      end
      return wit_pkg::REG_NONE;
   endfunction

   // registers
   wit_pkg::wit_mode_s mode_ff;
   wit_pkg::wit_mode_s nxt_mode;
   wit_pkg::wit_evt_s status_ff;
   wit_pkg::wit_evt_s irq_en_ff;
   logic watch_irq_ff;
   logic interval_irq_ff;
   logic irq_ff;

   // axi write side
   logic aw_hold_ff;
   logic [AXI_ADDR_W-1:0] aw_addr_ff;
   logic w_hold_ff;
   logic [31:0] w_data_ff;
   logic [3:0] w_strb_ff;
   logic bvalid_ff;
   logic [1:0] bresp_ff;
   logic do_write;
   wit_pkg::wit_reg_e wr_reg;
   logic lane0;

   // axi read side
   logic rvalid_ff;
   logic [31:0] rdata_ff;
   logic [1:0] rresp_ff;
   logic [31:0] rd_value;
   wit_pkg::wit_reg_e rd_reg;

   // timing chain
   logic [wit_pkg::DIV_LOG2-1:0] div_ff;
   logic div_tick;
   logic sub_meta_ff;
   logic sub_sync_ff;
   logic sub_prev_ff;
   logic sub_tick;
   logic watch_clock;
   logic [wit_pkg::PRE_W-1:0] pre_count;
   logic [wit_pkg::PRE_W:1] tap;
   logic [wit_pkg::CNT_W-1:0] cnt_ff;
   logic counting;
   logic watch_evt;
   logic interval_evt;
   wit_pkg::wit_evt_s evt;
   wit_pkg::wit_state_s state;

   // core clock divided by 128
   always_ff @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         div_ff <= '0;
      end else begin
         div_ff <= div_ff + {{(wit_pkg::DIV_LOG2-1){1'b0}}, 1'b1};
      end
   end
   assign div_tick = &div_ff;

   // subsystem clock synchroniser and rising edge
   always_ff @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         sub_meta_ff <= 1'b0;
         sub_sync_ff <= 1'b0;
         sub_prev_ff <= 1'b0;
      end else begin
         sub_meta_ff <= sub_clk_i;
         sub_sync_ff <= sub_meta_ff;
         sub_prev_ff <= sub_sync_ff;
      end
   end
   assign sub_tick = sub_sync_ff && !sub_prev_ff;

   assign watch_clock = mode_ff.clock_source_select ? sub_tick : div_tick;

   wit_prescaler #(
      .PRE_W(wit_pkg::PRE_W)
   ) u_prescaler (
      .core_clk_i(core_clk_i),
      .resetn_i(resetn_i),
      .tick_i(watch_clock),
      .clear_i(!mode_ff.timer_enable),
      .count_o(pre_count),
      .tap_o(tap)
   );

   // 5-bit counter on the 2^9 tap
   assign counting = mode_ff.timer_enable && mode_ff.counter_run;
   always_ff @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         cnt_ff <= '0;
      end else if (!counting) begin
         cnt_ff <= '0;
      end else if (tap[wit_pkg::COUNT_TAP]) begin
         cnt_ff <= cnt_ff + {{(wit_pkg::CNT_W-1){1'b0}}, 1'b1};
      end
   end

   // watch event select
   always_comb begin
      watch_evt = 1'b0;
      unique case (mode_ff.watch_period)
         wit_pkg::PER_2_14: watch_evt = tap[wit_pkg::COUNT_TAP] && (&cnt_ff);
         wit_pkg::PER_2_13: watch_evt = tap[wit_pkg::COUNT_TAP] && (&cnt_ff[wit_pkg::CNT_W-2:0]);
         wit_pkg::PER_2_5: watch_evt = tap[wit_pkg::MIN_TAP+1];
         wit_pkg::PER_2_4: watch_evt = tap[wit_pkg::MIN_TAP];
      endcase
      watch_evt = watch_evt && counting;
   end

   // interval event select
   assign interval_evt = mode_ff.timer_enable
      && tap[wit_pkg::MIN_TAP + int'(mode_ff.prescale_interval)];

   assign evt.watch = watch_evt;
   assign evt.interval = interval_evt;

   // event pulses
   always_ff @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         watch_irq_ff <= 1'b0;
         interval_irq_ff <= 1'b0;
      end else begin
         watch_irq_ff <= watch_evt;
         interval_irq_ff <= interval_evt;
      end
   end

   // axi write channels
   assign s_axi_awready_o = !aw_hold_ff && !bvalid_ff;
   assign s_axi_wready_o = !w_hold_ff && !bvalid_ff;
   assign do_write = aw_hold_ff && w_hold_ff && !bvalid_ff;
   assign wr_reg = decode(aw_addr_ff);
   assign lane0 = w_strb_ff[0];

   always_ff @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         aw_hold_ff <= 1'b0;
         aw_addr_ff <= '0;
      end else if (s_axi_awvalid_i && s_axi_awready_o) begin
         aw_hold_ff <= 1'b1;
         aw_addr_ff <= s_axi_awaddr_i;
      end else if (do_write) begin
         aw_hold_ff <= 1'b0;
      end
   end

   always_ff @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         w_hold_ff <= 1'b0;
         w_data_ff <= '0;
         w_strb_ff <= '0;
      end else if (s_axi_wvalid_i && s_axi_wready_o) begin
         w_hold_ff <= 1'b1;
         w_data_ff <= s_axi_wdata_i;
         w_strb_ff <= s_axi_wstrb_i;
      end else if (do_write) begin
         w_hold_ff <= 1'b0;
      end
   end

   always_ff @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         bvalid_ff <= 1'b0;
         bresp_ff <= wit_pkg::AXI_OKAY;
      end else if (do_write) begin
         bvalid_ff <= 1'b1;
         bresp_ff <= (wr_reg == wit_pkg::REG_NONE) ? wit_pkg::AXI_DECERR : wit_pkg::AXI_OKAY;
      end else if (s_axi_bready_i) begin
         bvalid_ff <= 1'b0;
      end
   end

   // mode register: byte write, bit set, bit clear
   always_comb begin
      nxt_mode = mode_ff;
      if (do_write && lane0) begin
         unique case (wr_reg)
            wit_pkg::REG_MODE: nxt_mode = w_data_ff[7:0];
            wit_pkg::REG_BIT_SET: nxt_mode = mode_ff | w_data_ff[7:0];
            wit_pkg::REG_BIT_CLR: nxt_mode = mode_ff & ~w_data_ff[7:0];
            default: nxt_mode = mode_ff;
         endcase
      end
   end

   always_ff @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         mode_ff <= wit_pkg::MODE_RST;
      end else begin
         mode_ff <= nxt_mode;
      end
   end

   // sticky status, set wins over clear
   always_ff @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         status_ff <= wit_pkg::EVT_RST;
      end else if (do_write && lane0 && wr_reg == wit_pkg::REG_CLEAR) begin
         status_ff <= (status_ff & ~w_data_ff[1:0]) | evt;
      end else begin
         status_ff <= status_ff | evt;
      end
   end

   always_ff @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         irq_en_ff <= wit_pkg::EVT_RST;
      end else if (do_write && lane0 && wr_reg == wit_pkg::REG_ENABLE) begin
         irq_en_ff <= w_data_ff[1:0];
      end
   end

   // interrupt level from enabled sticky bits
   always_ff @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         irq_ff <= 1'b0;
      end else begin
         irq_ff <= |(status_ff & irq_en_ff);
      end
   end

   // read data mux
   assign state.rsvd_hi = '0;
   assign state.counter = cnt_ff;
   assign state.rsvd_lo = '0;
   assign state.prescaler = pre_count;
   assign rd_reg = decode(s_axi_araddr_i);

   always_comb begin
      rd_value = '0;
      unique case (rd_reg)
         wit_pkg::REG_MODE: rd_value = {24'h000000, mode_ff};
         wit_pkg::REG_STATUS: rd_value = {30'h00000000, status_ff};
         wit_pkg::REG_ENABLE: rd_value = {30'h00000000, irq_en_ff};
         wit_pkg::REG_STATE: rd_value = state;
         default: rd_value = '0;
      endcase
   end

   // axi read channels
   assign s_axi_arready_o = !rvalid_ff;
   always_ff @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         rvalid_ff <= 1'b0;
         rdata_ff <= '0;
         rresp_ff <= wit_pkg::AXI_OKAY;
      end else if (s_axi_arvalid_i && s_axi_arready_o) begin
         rvalid_ff <= 1'b1;
         rdata_ff <= rd_value;
         rresp_ff <= (rd_reg == wit_pkg::REG_NONE) ? wit_pkg::AXI_DECERR : wit_pkg::AXI_OKAY;
      end else if (s_axi_rready_i) begin
         rvalid_ff <= 1'b0;
      end
   end

   assign s_axi_bvalid_o = bvalid_ff;
   assign s_axi_bresp_o = bresp_ff;
   assign s_axi_rvalid_o = rvalid_ff;
   assign s_axi_rdata_o = rdata_ff;
   assign s_axi_rresp_o = rresp_ff;
   assign watch_irq_o = watch_irq_ff;
   assign interval_irq_o = interval_irq_ff;
   assign irq_o = irq_ff;

endmodule // wit_top
`default_nettype wire

// file: sim/wit_top_assertions.sv
// checker for the watch interval timer bus and event ports
// assumes binding into wit_top, one clock domain
`timescale 1ns/1ps
`default_nettype none
module wit_top_assertions (
   // clock and reset
   input wire logic core_clk_i,
   input wire logic resetn_i,
   // bus handshakes
   input wire logic s_axi_awvalid_i,
   input wire logic s_axi_awready_o,
   input wire logic s_axi_wvalid_i,
   input wire logic s_axi_wready_o,
   input wire logic s_axi_bvalid_o,
   input wire logic s_axi_bready_i,
   input wire logic [1:0] s_axi_bresp_o,
   input wire logic s_axi_arvalid_i,
   input wire logic s_axi_arready_o,
   input wire logic s_axi_rvalid_o,
   input wire logic s_axi_rready_i,
   input wire logic [31:0] s_axi_rdata_o,
   // events
   input wire logic watch_irq_o,
   input wire logic interval_irq_o,
   input wire logic irq_o
);
   default clocking @(posedge core_clk_i); endclocking
   default disable iff (!resetn_i);
   AST_BHOLD: assert property (s_axi_bvalid_o && !s_axi_bready_i
      |=> s_axi_bvalid_o && $stable(s_axi_bresp_o))
      else $error("write response dropped early");
   AST_RHOLD: assert property (s_axi_rvalid_o && !s_axi_rready_i
      |=> s_axi_rvalid_o && $stable(s_axi_rdata_o))
      else $error("read data dropped early");
   AST_WBUSY: assert property (s_axi_bvalid_o |-> !s_axi_awready_o && !s_axi_wready_o)
      else $error("write taken while response pending");
   AST_RBUSY: assert property (s_axi_rvalid_o |-> !s_axi_arready_o)
      else $error("read taken while data pending");
   AST_RD_ANS: assert property (s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o)
      else $error("read answer late");
   AST_WR_ANS: assert property (s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o
      |-> ##[1:2] s_axi_bvalid_o)
      else $error("write answer late");
   AST_WGAP: assert property (watch_irq_o |=> !watch_irq_o [*8])
      else $error("watch events too close");
   AST_IGAP: assert property (interval_irq_o |=> !interval_irq_o [*8])
      else $error("interval events too close");
   cover property (watch_irq_o);
   cover property (interval_irq_o);
   cover property (irq_o);
endmodule // wit_top_assertions
bind wit_top wit_top_assertions wit_top_assertions_i (.core_clk_i(core_clk_i), .resetn_i(resetn_i),
   .s_axi_awvalid_i(s_axi_awvalid_i), .s_axi_awready_o(s_axi_awready_o), .s_axi_wvalid_i(s_axi_wvalid_i),
   .s_axi_wready_o(s_axi_wready_o), .s_axi_bvalid_o(s_axi_bvalid_o), .s_axi_bready_i(s_axi_bready_i),
   .s_axi_bresp_o(s_axi_bresp_o), .s_axi_arvalid_i(s_axi_arvalid_i), .s_axi_arready_o(s_axi_arready_o),
   .s_axi_rvalid_o(s_axi_rvalid_o), .s_axi_rready_i(s_axi_rready_i), .s_axi_rdata_o(s_axi_rdata_o),
   .watch_irq_o(watch_irq_o), .interval_irq_o(interval_irq_o), .irq_o(irq_o));
`default_nettype wire

// file: sim/wit_top_tb.sv
// self-checking bench for the watch interval timer
// assumes wit_pkg, wit_top and the checker compiled first
`timescale 1ns/1ps
`default_nettype none
module wit_top_tb;
   typedef struct packed {logic [15:0] wi; logic [31:0] wd; logic [15:0] ri;
      logic [31:0] re; logic [1:0] rs;} wit_row_s;
   localparam wit_row_s ROWS [6] = '{
      '{wit_pkg::IDX_MODE, 32'hF2, wit_pkg::IDX_MODE, 32'hF2, 2'h0},
      '{wit_pkg::IDX_BIT_CLR, 32'hF0, wit_pkg::IDX_MODE, 32'h02, 2'h0},
      '{wit_pkg::IDX_BIT_SET, 32'h01, wit_pkg::IDX_MODE, 32'h03, 2'h0},
      '{wit_pkg::IDX_ENABLE, 32'h03, wit_pkg::IDX_ENABLE, 32'h03, 2'h0},
      '{wit_pkg::IDX_CLEAR, 32'h03, wit_pkg::IDX_CLEAR, 32'h00, 2'h0},
      '{16'hFF96, 32'h01, 16'hFF96, 32'h00, 2'h3}};
   logic clk = 0, resetn = 0, sub_clk = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
   logic [19:0] awaddr = '0, araddr = '0;
   logic [31:0] wdata = '0, rdata, rd_got;
   logic [3:0] wstrb = '0;
   logic awready, wready, bvalid, arready, rvalid, watch_irq, interval_irq, irq;
   logic [1:0] bresp, rresp, b_got, r_got;
   int miscompares = 0, cmp_count = 0, cycles = 0, cw, ci;
   always #5 clk = ~clk;
   always begin
      repeat (8) @(posedge clk);
      sub_clk <= ~sub_clk;
   end
   wit_top wit_top_i (.core_clk_i(clk), .resetn_i(resetn), .sub_clk_i(sub_clk),
      .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready), .s_axi_awaddr_i(awaddr),
      .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready), .s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb),
      .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready), .s_axi_bresp_o(bresp),
      .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready), .s_axi_araddr_i(araddr),
      .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
      .watch_irq_o(watch_irq), .interval_irq_o(interval_irq), .irq_o(irq));
   task automatic final_report();
      $display("compares=%0d mismatches=%0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   always @(posedge clk) begin
      cycles++;
      if (cycles == 90000) begin
         miscompares++;
         final_report();
      end
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         miscompares++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [15:0] idx, input logic [31:0] d);
      logic aw_t, w_t, b_t;
      @(posedge clk);
      awaddr <= {2'h0, idx, 2'h0};
      wdata <= d;
      wstrb <= 4'h1;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      b_t = 1'b0;
      while (!b_t) begin
         @(negedge clk);
         aw_t = awvalid & awready;
         w_t = wvalid & wready;
         b_t = bvalid;
         b_got = bresp;
         @(posedge clk);
         if (aw_t) awvalid <= 1'b0;
         if (w_t) wvalid <= 1'b0;
      end
      bready <= 1'b0;
   endtask
   task automatic rdchk(input logic [15:0] idx, input logic [31:0] m, input logic [31:0] exp);
      logic a_t;
      @(posedge clk);
      araddr <= {2'h0, idx, 2'h0};
      arvalid <= 1'b1;
      rready <= 1'b1;
      forever begin
         @(negedge clk);
         a_t = arvalid & arready;
         rd_got = rdata;
         r_got = rresp;
         if (rvalid) break;
         @(posedge clk);
         if (a_t) arvalid <= 1'b0;
      end
      @(posedge clk);
      rready <= 1'b0;
      chk(rd_got & m, exp);
   endtask
   task automatic wait_pulse(input int sel);
      do @(negedge clk); while (!(sel ? interval_irq : watch_irq));
   endtask
   task automatic measure(input int sel, input int exp);
      int n;
      wait_pulse(sel);
      n = 0;
      do begin
         @(negedge clk);
         n++;
      end while (!(sel ? interval_irq : watch_irq));
      chk(n, exp);
   endtask
   task automatic count(input int len);
      cw = 0;
      ci = 0;
      repeat (len) begin
         @(negedge clk);
         cw += watch_irq;
         ci += interval_irq;
      end
   endtask
   initial begin
      repeat (2) @(posedge clk);
      resetn <= 1'b1;
      rdchk(wit_pkg::IDX_MODE, 32'hFF, 32'h0);
      rdchk(wit_pkg::IDX_STATUS, 32'h3, 32'h0);
      $display("end reset");
      foreach (ROWS[j]) begin
         wr(ROWS[j].wi, ROWS[j].wd);
         chk(b_got, ROWS[j].rs);
         rdchk(ROWS[j].ri, 32'hFFFFFFFF, ROWS[j].re);
         chk(r_got, ROWS[j].rs);
      end
      $display("end table");
      for (int i = 0; i < 3; i++) begin
         wr(wit_pkg::IDX_MODE, 32'h0);
         wr(wit_pkg::IDX_MODE, {24'h0, 1'b0, i[2:0], ((i == 1) ? 2'h2 : 2'h3), 2'h3});
         measure(1, 2048 << i);
         measure(0, (i == 1) ? 4096 : 2048);
      end
      wr(wit_pkg::IDX_MODE, 32'h0);
      wr(wit_pkg::IDX_MODE, 32'h8F);
      measure(1, 256);
      measure(0, 256);
      $display("end periods");
      wr(wit_pkg::IDX_MODE, 32'h0);
      wr(wit_pkg::IDX_MODE, 32'h0D);
      wait_pulse(1);
      count(4096);
      chk(cw, 0);
      chk(ci, 2);
      rdchk(wit_pkg::IDX_STATE, 32'h001F0000, 32'h0);
      chk({31'h0, rd_got[10:0] == 11'h0}, 32'h0);
      wr(wit_pkg::IDX_MODE, 32'h0);
      count(4096);
      chk(cw + ci, 0);
      rdchk(wit_pkg::IDX_STATE, 32'h001F07FF, 32'h0);
      $display("end run bits");
      wr(wit_pkg::IDX_ENABLE, 32'h1);
      wr(wit_pkg::IDX_CLEAR, 32'h3);
      wr(wit_pkg::IDX_MODE, 32'h0F);
      wait_pulse(0);
      repeat (2) @(negedge clk);
      chk(irq, 1'b1);
      rdchk(wit_pkg::IDX_STATUS, 32'h1, 32'h1);
      wr(wit_pkg::IDX_ENABLE, 32'h0);
      @(negedge clk);
      chk(irq, 1'b0);
      wr(wit_pkg::IDX_ENABLE, 32'h1);
      @(negedge clk);
      chk(irq, 1'b1);
      wr(wit_pkg::IDX_CLEAR, 32'h3);
      @(negedge clk);
      chk(irq, 1'b0);
      $display("end interrupt");
      @(posedge clk);
      resetn <= 1'b0;
      @(posedge clk);
      resetn <= 1'b1;
      rdchk(wit_pkg::IDX_MODE, 32'hFF, 32'h0);
      $display("end mid reset");
      final_report();
   end
endmodule // wit_top_tb
`default_nettype wire
